// [design/swm_pkg.sv]
package swm_pkg;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] SWM_SYSCTL0_OFS = 4'h0; // system_control_zero
   localparam logic [3:0] SWM_SYSCTL2_OFS = 4'h1; // system_control_two
   localparam logic [3:0] SWM_SYSCTL3_OFS = 4'h2; // system_control_three
   localparam logic [3:0] SWM_STAT_OFS = 4'h3; // Status / mode readback
   localparam logic [3:0] SWM_IRQ_STAT_OFS = 4'h4; // Sticky event bits
   localparam logic [3:0] SWM_IRQ_MASK_OFS = 4'h5; // Interrupt mask
   localparam logic [3:0] SWM_CMD_OFS = 4'h6; // Warm-up start command

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int SWM_WEND_BIT = 0; // warmup_end_flag in ctl0
   localparam int SWM_WTIME_LSB = 0; // warmup_time_field in ctl2
   localparam int SWM_STBY_LSB = 2; // standby_select in ctl2
   localparam int SWM_LSEL_BIT = 0; // lockup_time_select in ctl3
   localparam int SWM_LFLAG_BIT = 1; // lockup_flag in ctl3
   localparam int SWM_PLLEN_BIT = 2; // PLL in use, ctl3
   localparam int SWM_CMD_WUP_BIT = 0; // Start software warm-up
   localparam int SWM_CMD_LUP_BIT = 1; // Start lock-up count
   localparam int SWM_EV_WUP = 0; // Event: warm-up done
   localparam int SWM_EV_LUP = 1; // Event: lock-up done
   localparam int SWM_EV_STBY = 2; // Event: standby entered

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] SWM_WTIME_RST = 2'h1;
   localparam logic [1:0] SWM_STBY_RST = 2'h0;
   localparam logic SWM_LSEL_RST = 1'b0;
   localparam logic SWM_PLLEN_RST = 1'b0;
   localparam logic [2:0] SWM_MASK_RST = 3'h0;

   // ----------------------------------------------------------------
   // Timing counts, in input clock periods
   // ----------------------------------------------------------------
   localparam int SWM_CNT_W = 17;
   localparam logic [16:0] SWM_WUP_2P8 = 17'h00100;
   localparam logic [16:0] SWM_WUP_2P14 = 17'h04000;
   localparam logic [16:0] SWM_WUP_2P16 = 17'h10000;
   localparam logic [16:0] SWM_LUP_2P16 = 17'h10000;
   localparam logic [16:0] SWM_LUP_2P12 = 17'h01000;

   // ----------------------------------------------------------------
   // Operating modes and standby select codes
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      SWM_NORMAL = 5'b00001,
      SWM_SLOW = 5'b00010,
      SWM_IDLE = 5'b00100,
      SWM_SLEEP = 5'b01000,
      SWM_STOP = 5'b10000
   } swm_mode_t;

   localparam logic [1:0] SWM_SEL_STOP = 2'h1;
   localparam logic [1:0] SWM_SEL_SLEEP = 2'h2;
   localparam logic [1:0] SWM_SEL_IDLE = 2'h3;
endpackage

// [design/swm_interval_counter.sv]
`timescale 1ns/1ps
// Down counter: loads a length, stays busy until it reaches zero
module swm_interval_counter #(
   parameter int W = 17
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic start_i,
   input wire logic [W-1:0] length_i,
   output logic busy_o,
   output logic done_o
);
   logic [W-1:0] cnt_ff;
   logic done_ff;

   // ----------------------------------------------------------------
   // Count
   // ----------------------------------------------------------------
   // Restart wins over a running count so a retrigger is clean
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt_ff <= '0;
         done_ff <= 1'b0;
      end
      else if (start_i)
      begin
         cnt_ff <= length_i;
         done_ff <= 1'b0;
      end
      else if (cnt_ff != '0)
      begin
         cnt_ff <= cnt_ff - 1'b1;
         done_ff <= (cnt_ff == {{(W-1){1'b0}}, 1'b1});
      end
      else
      begin
         done_ff <= 1'b0;
      end
   end

   assign busy_o = (cnt_ff != '0);
   assign done_o = done_ff;
endmodule // swm_interval_counter

// [design/swm_reg_if.sv]
`timescale 1ns/1ps
// Register read mux: read data one cycle after the strobe
module swm_reg_if (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic rd_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] v0_i,
   input wire logic [7:0] v2_i,
   input wire logic [7:0] v3_i,
   input wire logic [7:0] vst_i,
   input wire logic [7:0] vis_i,
   input wire logic [7:0] vim_i,
   output logic [7:0] rdata_o
);
   import swm_pkg::*;

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   // Unmapped offsets and idle cycles read as zero
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rdata_o <= 8'h00;
      else if (!rd_i)
         rdata_o <= 8'h00;
      else
      begin
         case (addr_i)
            SWM_SYSCTL0_OFS: rdata_o <= v0_i;
            SWM_SYSCTL2_OFS: rdata_o <= v2_i;
            SWM_SYSCTL3_OFS: rdata_o <= v3_i;
            SWM_STAT_OFS: rdata_o <= vst_i;
            SWM_IRQ_STAT_OFS: rdata_o <= vis_i;
            SWM_IRQ_MASK_OFS: rdata_o <= vim_i;
            default: rdata_o <= 8'h00;
         endcase
      end
   end
endmodule // swm_reg_if

// [design/swm_sequencer.sv]
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
// Contract
// - halt bit enters mode from standby_select
// - doze bit always selects IDLE mode
// - SLOW accepted right after warm-up
// - warm-up lengths 2^8, 2^14, 2^16
// - lock-up 2^16 when 0, 2^12 when 1
module swm_sequencer (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   // Register port
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // Core side
   input wire logic halt_i,
   input wire logic doze_i,
   input wire logic standby_req_i,
   input wire logic wake_i,
   input wire logic [1:0] mode_req_i,
   input wire logic mode_req_vld_i,
   output swm_pkg::swm_mode_t mode_o,
   output logic pll_on_o,
   output logic irq_o
);
   import swm_pkg::*;

   // ----------------------------------------------------------------
   // Reset synchroniser
   // ----------------------------------------------------------------
   logic rst_meta_ff; // First stage, read only by the second
   logic rst_n_ff; // Released reset used by all logic

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rst_meta_ff <= 1'b0;
         rst_n_ff <= 1'b0;
      end
      else
      begin
         rst_meta_ff <= 1'b1;
         rst_n_ff <= rst_meta_ff;
      end
   end

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [1:0] wtime_ff; // warmup_time_field
   logic [1:0] stby_ff; // standby_select
   logic lsel_ff; // lockup_time_select
   logic pllen_ff; // PLL in use
   logic [2:0] ist_ff; // Sticky event status
   logic [2:0] imask_ff; // Interrupt mask
   swm_mode_t mode_ff; // Current operating mode
   swm_mode_t nxt_mode; // Next mode
   logic wu_pend_ff; // Warm-up pending or running
   logic wr_ctl2;
   logic wr_ctl3;
   logic wr_ist;
   logic wr_imask;
   logic wr_cmd;
   logic wu_start; // Launch oscillator warm-up
   logic lu_start; // Launch PLL lock-up
   logic [SWM_CNT_W-1:0] wu_len;
   logic [SWM_CNT_W-1:0] lu_len;
   logic wu_busy;
   logic wu_done;
   logic lu_busy;
   logic lu_done;
   logic stby_ev; // Standby entered this cycle
   logic [2:0] ev; // Event vector
   logic [7:0] v0;
   logic [7:0] v2;
   logic [7:0] v3;
   logic [7:0] vst;

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   assign wr_ctl2 = wr_i && (addr_i == SWM_SYSCTL2_OFS);
   assign wr_ctl3 = wr_i && (addr_i == SWM_SYSCTL3_OFS);
   assign wr_ist = wr_i && (addr_i == SWM_IRQ_STAT_OFS);
   assign wr_imask = wr_i && (addr_i == SWM_IRQ_MASK_OFS);
   assign wr_cmd = wr_i && (addr_i == SWM_CMD_OFS);

   // ----------------------------------------------------------------
   // Warm-up time and standby select
   // ----------------------------------------------------------------
   // The field is frozen during warm-up; a write then is dropped
   // because the running count already took its length
   always_ff @(posedge clk_sys_i or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         wtime_ff <= SWM_WTIME_RST;
         stby_ff <= SWM_STBY_RST;
      end
      else if (wr_ctl2)
      begin
         stby_ff <= wdata_i[SWM_STBY_LSB +: 2];
         if (!wu_pend_ff)
            wtime_ff <= wdata_i[SWM_WTIME_LSB +: 2];
      end
   end

   // ----------------------------------------------------------------
   // Lock-up time select and PLL enable
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         lsel_ff <= SWM_LSEL_RST;
         pllen_ff <= SWM_PLLEN_RST;
      end
      else if (wr_ctl3)
      begin
         lsel_ff <= wdata_i[SWM_LSEL_BIT];
         pllen_ff <= wdata_i[SWM_PLLEN_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Interval lengths
   // ----------------------------------------------------------------
   always_comb
   begin
      case (wtime_ff)
         2'h2: wu_len = SWM_WUP_2P14;
         2'h3: wu_len = SWM_WUP_2P16;
         default: wu_len = SWM_WUP_2P8;
      endcase
   end

   assign lu_len = lsel_ff ? SWM_LUP_2P12 : SWM_LUP_2P16;

   // ----------------------------------------------------------------
   // Warm-up and lock-up launch
   // ----------------------------------------------------------------
   // Hardware warm-up on wake from STOP or SLEEP; software warm-up
   // by command in any mode. Lock-up follows whenever warm-up ends.
   assign wu_start = (wake_i && (mode_ff == SWM_STOP ||
                      mode_ff == SWM_SLEEP)) ||
                     (wr_cmd && wdata_i[SWM_CMD_WUP_BIT]);
   assign lu_start = wu_done || (wr_cmd && wdata_i[SWM_CMD_LUP_BIT]);

   swm_interval_counter #(
      .W(SWM_CNT_W)
   ) u_warmup (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_ff),
      .start_i(wu_start),
      .length_i(wu_len),
      .busy_o(wu_busy),
      .done_o(wu_done)
   );

   swm_interval_counter #(
      .W(SWM_CNT_W)
   ) u_lockup (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_ff),
      .start_i(lu_start),
      .length_i(lu_len),
      .busy_o(lu_busy),
      .done_o(lu_done)
   );

   // ----------------------------------------------------------------
   // Warm-up end flag
   // ----------------------------------------------------------------
   // Set from the launch until the count completes
   always_ff @(posedge clk_sys_i or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         wu_pend_ff <= 1'b0;
      else if (wu_start)
         wu_pend_ff <= 1'b1;
      else if (wu_done)
         wu_pend_ff <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Mode sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_mode = mode_ff;
      case (mode_ff)
         SWM_NORMAL, SWM_SLOW:
         begin
            if (standby_req_i)
            begin
               if (doze_i)
                  nxt_mode = SWM_IDLE;
               else if (halt_i)
               begin
                  case (stby_ff)
                     SWM_SEL_STOP: nxt_mode = SWM_STOP;
                     SWM_SEL_SLEEP: nxt_mode = SWM_SLEEP;
                     SWM_SEL_IDLE: nxt_mode = SWM_IDLE;
                     default: nxt_mode = mode_ff;
                  endcase
               end
            end
            else if (mode_req_vld_i)
            begin
               // SLOW is taken without waiting on any flag
               if (mode_req_i == 2'h1)
                  nxt_mode = SWM_SLOW;
               else if (mode_req_i == 2'h0)
                  nxt_mode = SWM_NORMAL;
            end
         end
         SWM_STOP, SWM_SLEEP:
         begin
            // Leave standby once the oscillator has warmed up
            if (wu_done)
               nxt_mode = (mode_req_i == 2'h1) ? SWM_SLOW : SWM_NORMAL;
         end
         SWM_IDLE:
         begin
            if (wake_i)
               nxt_mode = SWM_NORMAL;
         end
         default: nxt_mode = SWM_NORMAL;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         mode_ff <= SWM_NORMAL;
      else
         mode_ff <= nxt_mode;
   end

   assign stby_ev = (nxt_mode != mode_ff) &&
                    (nxt_mode == SWM_STOP || nxt_mode == SWM_SLEEP ||
                     nxt_mode == SWM_IDLE);

   // ----------------------------------------------------------------
   // Interrupt status and mask
   // ----------------------------------------------------------------
   assign ev = {stby_ev, lu_done, wu_done};

   // Set wins over write-one-to-clear in the same cycle
   always_ff @(posedge clk_sys_i or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         ist_ff <= 3'h0;
      else
         ist_ff <= (ist_ff & ~(wr_ist ? wdata_i[2:0] : 3'h0)) | ev;
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         imask_ff <= SWM_MASK_RST;
      else if (wr_imask)
         imask_ff <= wdata_i[2:0];
   end

   // Registered so the line is glitch free
   always_ff @(posedge clk_sys_i or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         irq_o <= 1'b0;
      else
         irq_o <= |(((ist_ff & ~(wr_ist ? wdata_i[2:0] : 3'h0)) | ev)
                    & imask_ff);
   end

   // ----------------------------------------------------------------
   // Readback
   // ----------------------------------------------------------------
   assign v0 = {7'h00, wu_pend_ff};
   assign v2 = {4'h0, stby_ff, wtime_ff};
   assign v3 = {5'h00, pllen_ff, lu_busy, lsel_ff};
   assign vst = {wu_busy, 2'h0, mode_ff};

   swm_reg_if u_regs (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_ff),
      .rd_i(rd_i),
      .addr_i(addr_i),
      .v0_i(v0),
      .v2_i(v2),
      .v3_i(v3),
      .vst_i(vst),
      .vis_i({5'h00, ist_ff}),
      .vim_i({5'h00, imask_ff}),
      .rdata_o(rdata_o)
   );

   assign mode_o = mode_ff;
   assign pll_on_o = pllen_ff;
endmodule // swm_sequencer

// [verif/swm_sequencer_assertions.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checker for the standby sequencer
// ------------------------------------------------------------
module swm_sequencer_chk
   import swm_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic standby_req_i,
   input wire logic doze_i,
   input wire logic wake_i,
   input wire logic [1:0] mode_req_i,
   input wire swm_pkg::swm_mode_t mode_o
);
   logic stopped; // Clock stopped: STOP or SLEEP
   logic [16:0] dwell_ff; // Cycles spent stopped
   assign stopped = mode_o[4] | mode_o[3];
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   // Dwell counter, cleared whenever the clock runs
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         dwell_ff <= 17'h00000;
      else
         dwell_ff <= stopped ? dwell_ff + 17'h00001 : 17'h00000;
   end
   chk_read_quiet: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data not zero outside read slot");
   chk_mode_onehot: assert property ($onehot(mode_o))
      else $error("mode not one-hot");
   chk_doze_idle: assert property (standby_req_i && doze_i &&
      mode_o == SWM_NORMAL |=> mode_o == SWM_IDLE)
      else $error("doze standby did not give idle");
   chk_enter_cause: assert property (mode_o != SWM_NORMAL &&
      mode_o != SWM_SLOW && $past(mode_o) inside {SWM_NORMAL, SWM_SLOW}
      |-> $past(standby_req_i))
      else $error("standby entered without request");
   chk_warmup_floor: assert property ($past(stopped) && !stopped
      |-> $past(dwell_ff) >= 17'h00100)
      else $error("left stop before shortest warm-up");
   chk_exit_target: assert property ($past(stopped) && !stopped
      |-> mode_o == ($past(mode_req_i) == 2'h1 ? SWM_SLOW : SWM_NORMAL))
      else $error("wrong mode after warm-up");
   chk_idle_wake: assert property (mode_o == SWM_IDLE && wake_i
      |=> mode_o == SWM_NORMAL)
      else $error("idle did not wake");
   chk_idle_stay: assert property (mode_o == SWM_IDLE && !wake_i
      |=> mode_o == SWM_IDLE)
      else $error("idle left without wake");
endmodule // swm_sequencer_chk

bind swm_sequencer swm_sequencer_chk u_chk (
   .clk_sys_i(clk_sys_i),
   .nrst_i(nrst_i),
   .rd_i(rd_i),
   .rdata_o(rdata_o),
   .standby_req_i(standby_req_i),
   .doze_i(doze_i),
   .wake_i(wake_i),
   .mode_req_i(mode_req_i),
   .mode_o(mode_o)
);

// [verif/swm_core_model.sv]
`timescale 1ns/1ps
// Core software: a mode request goes out five instructions after go
module swm_core_model (
   input wire logic clk_sys_i,
   input wire logic go_i,
   input wire logic [1:0] tgt_i,
   output logic [1:0] mode_req_o = 2'h0,
   output logic mode_req_vld_o = 1'b0
);
   logic [2:0] wait_ff = 3'h0; // Instructions still to retire
   // One instruction per cycle; flag polling is done by the caller
   always_ff @(posedge clk_sys_i)
   begin
      mode_req_o <= tgt_i;
      mode_req_vld_o <= 1'b0;
      if (go_i)
         wait_ff <= 3'h5;
      else if (wait_ff != 3'h0)
      begin
         wait_ff <= wait_ff - 3'h1;
         mode_req_vld_o <= (wait_ff == 3'h1);
      end
   end
endmodule // swm_core_model

// [verif/tb.sv]
`timescale 1ns/1ps
module tb;
   import swm_pkg::*;
   typedef struct packed {logic h; logic d; logic [1:0] s; logic [4:0] m;}
      swm_row_t;
   logic clk_sys_i, nrst_i, wr_i, rd_i, halt_i, doze_i, go, vld;
   logic standby_req_i, wake_i, pll_on_o, irq_o;
   logic [3:0] addr_i;
   logic [7:0] wdata_i, rdata_o;
   logic [1:0] tgt, mreq;
   swm_mode_t mode_o;
   int n_mismatch = 0, cmp_count = 0, n;
   // Standby table: halt, doze, select, expected mode
   swm_row_t rows [6] = '{
      '{1'b1, 1'b0, 2'h1, SWM_STOP}, '{1'b1, 1'b0, 2'h2, SWM_SLEEP},
      '{1'b1, 1'b0, 2'h3, SWM_IDLE}, '{1'b0, 1'b1, 2'h1, SWM_IDLE},
      '{1'b1, 1'b1, 2'h2, SWM_IDLE}, '{1'b1, 1'b0, 2'h0, SWM_NORMAL}};
   swm_sequencer uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .halt_i(halt_i), .doze_i(doze_i),
      .standby_req_i(standby_req_i), .wake_i(wake_i), .mode_req_i(mreq),
      .mode_req_vld_i(vld), .mode_o(mode_o), .pll_on_o(pll_on_o),
      .irq_o(irq_o));
   swm_core_model core (.clk_sys_i(clk_sys_i), .go_i(go), .tgt_i(tgt),
      .mode_req_o(mreq), .mode_req_vld_o(vld));
   // ---------------------------------------------------------
   // Bus and check tasks
   // ---------------------------------------------------------
   task automatic chk(input string nm, input logic [7:0] g,
      input logic [7:0] e);
      cmp_count++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_sys_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      logic [7:0] v;
      rd(a, v);
      chk("register", v, e);
   endtask
   // Pulse standby request (0) or wake (1) for one cycle
   task automatic pulse(input bit w);
      @(posedge clk_sys_i);
      if (w) wake_i <= 1'b1;
      else standby_req_i <= 1'b1;
      @(posedge clk_sys_i);
      wake_i <= 1'b0;
      standby_req_i <= 1'b0;
   endtask
   // Cycles until the clock runs again, bounded
   task automatic wait_run(output int c);
      c = 0;
      while ((mode_o[4] | mode_o[3]) === 1'b1 && c < 70000)
      begin
         @(posedge clk_sys_i);
         #1 c++;
      end
   endtask
   // Polls the lock-up flag; two cycles per read
   task automatic wait_lock(output int c);
      logic [7:0] v;
      c = 0;
      v = 8'h02;
      while (v[1] !== 1'b0 && c < 70000)
      begin
         rd(SWM_SYSCTL3_OFS, v);
         c += 2;
      end
   endtask
   task automatic kick(input logic [1:0] t);
      tgt <= t;
      @(posedge clk_sys_i);
      go <= 1'b1;
      @(posedge clk_sys_i);
      go <= 1'b0;
      repeat (8) @(posedge clk_sys_i);
      #1 chk("mode", {3'h0, mode_o}, {3'h0, t == 2'h1 ? SWM_SLOW : SWM_NORMAL});
   endtask
   task automatic close_out;
      if (n_mismatch == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      clk_sys_i = 1'b0;
      forever #25 clk_sys_i = ~clk_sys_i;
   end
   // Watchdog, well beyond the fifty thousand cycles planned
   initial
   begin
      repeat (70000) @(posedge clk_sys_i);
      n_mismatch++;
      close_out;
   end
   // ---------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------
   initial
   begin
      {nrst_i, wr_i, rd_i, halt_i, doze_i, go, standby_req_i, wake_i} = '0;
      addr_i = 4'h0;
      wdata_i = 8'h00;
      tgt = 2'h0;
      repeat (12) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      rdc(SWM_SYSCTL2_OFS, 8'h01);
      rdc(SWM_SYSCTL3_OFS, 8'h00);
      rdc(SWM_STAT_OFS, 8'h01);
      rdc(SWM_IRQ_MASK_OFS, 8'h00);
      rdc(4'hF, 8'h00);
      wr(SWM_SYSCTL3_OFS, 8'h05);
      #1 chk("pll", {7'h0, pll_on_o}, 8'h01);
      wr(SWM_SYSCTL3_OFS, 8'h01);
      foreach (rows[i])
      begin
         @(posedge clk_sys_i);
         halt_i <= rows[i].h;
         doze_i <= rows[i].d;
         wr(SWM_SYSCTL2_OFS, {4'h0, rows[i].s, 2'h1});
         pulse(0);
         @(posedge clk_sys_i);
         #1 chk("mode", {3'h0, mode_o}, {3'h0, rows[i].m});
         if (rows[i].m != SWM_NORMAL) pulse(1);
         wait_run(n);
         if (rows[i].m inside {SWM_STOP, SWM_SLEEP}) wait_lock(n);
         @(posedge clk_sys_i);
         #1 chk("back", {3'h0, mode_o}, 8'h01);
      end
      // Sleep, exit to SLOW, write to warm-up field refused
      tgt <= 2'h1;
      wr(SWM_IRQ_STAT_OFS, 8'h07);
      wr(SWM_SYSCTL2_OFS, 8'h09);
      pulse(0);
      pulse(1);
      fork
         wait_run(n);
         begin
            rdc(SWM_SYSCTL0_OFS, 8'h01);
            wr(SWM_SYSCTL2_OFS, 8'h0A);
            rdc(SWM_SYSCTL2_OFS, 8'h09);
         end
      join
      chk("wup 2^8", {7'h0, n >= 254 && n <= 259}, 8'h01);
      chk("exit", {3'h0, mode_o}, {3'h0, SWM_SLOW});
      rdc(SWM_SYSCTL0_OFS, 8'h00);
      wait_lock(n);
      chk("lock 2^12", {7'h0, n >= 4086 && n <= 4100}, 8'h01);
      // Events, mask and write-one-to-clear
      rdc(SWM_IRQ_STAT_OFS, 8'h07);
      chk("irq", {7'h0, irq_o}, 8'h00);
      wr(SWM_IRQ_MASK_OFS, 8'h04);
      @(posedge clk_sys_i);
      #1 chk("irq", {7'h0, irq_o}, 8'h01);
      wr(SWM_IRQ_STAT_OFS, 8'h04);
      @(posedge clk_sys_i);
      #1 chk("irq", {7'h0, irq_o}, 8'h00);
      rdc(SWM_IRQ_STAT_OFS, 8'h03);
      // Stop with the 2^14 warm-up, exit to NORMAL
      kick(2'h0);
      wr(SWM_SYSCTL2_OFS, 8'h06);
      pulse(0);
      pulse(1);
      wait_run(n);
      chk("wup 2^14", {7'h0, n >= 16382 && n <= 16387}, 8'h01);
      chk("exit", {3'h0, mode_o}, 8'h01);
      wait_lock(n);
      // NORMAL to SLOW, software warm-up, back to NORMAL
      rdc(SWM_SYSCTL0_OFS, 8'h00);
      wr(SWM_SYSCTL2_OFS, 8'h01);
      kick(2'h1);
      wr(SWM_CMD_OFS, 8'h01);
      rdc(SWM_SYSCTL0_OFS, 8'h01);
      repeat (300) @(posedge clk_sys_i);
      rdc(SWM_SYSCTL0_OFS, 8'h00);
      kick(2'h0);
      rdc(SWM_STAT_OFS, 8'h01);
      // Longest settings: 2^16 warm-up beside a 2^16 lock-up
      wr(SWM_SYSCTL3_OFS, 8'h04);
      wr(SWM_SYSCTL2_OFS, 8'h03);
      wr(SWM_CMD_OFS, 8'h03);
      repeat (16400) @(posedge clk_sys_i);
      rdc(SWM_STAT_OFS, 8'h81);
      rdc(SWM_SYSCTL0_OFS, 8'h01);
      rdc(SWM_SYSCTL3_OFS, 8'h06);
      // Reset in mid warm-up: all back to reset values
      @(posedge clk_sys_i);
      nrst_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      #1 chk("irq", {7'h0, irq_o}, 8'h00);
      chk("pll", {7'h0, pll_on_o}, 8'h00);
      rdc(SWM_SYSCTL0_OFS, 8'h00);
      rdc(SWM_SYSCTL2_OFS, 8'h01);
      rdc(SWM_SYSCTL3_OFS, 8'h00);
      rdc(SWM_STAT_OFS, 8'h01);
      close_out;
   end
endmodule // tb
